// ### qbt_transceiver.sv
`timescale 1ns/1ps
`include "qbt_map.svh"

module qbt_transceiver (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`QBT_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Local logic, driver side
	input wire logic [3:0] word_a,
	input wire logic [3:0] word_b,
	input wire logic word_select,
	input wire logic drive_clock,
	// Shared bus lines, open collector
	input wire logic [3:0] bus_in,
	output logic [3:0] bus_out,
	output logic [3:0] bus_oe_n,
	// Receiver outputs, three-state
	output logic [3:0] rx_data,
	output logic [3:0] rx_oe_n
);

	qbt_pkg::qbt_nibble_t word_a_s;
	qbt_pkg::qbt_nibble_t word_b_s;
	qbt_pkg::qbt_nibble_t bus_s;
	qbt_pkg::qbt_nibble_t drv_q;
	qbt_pkg::qbt_nibble_t rx_lat_q;
	qbt_pkg::qbt_nibble_t bus_oe_n_q;
	qbt_pkg::qbt_nibble_t bus_out_q;
	qbt_pkg::qbt_nibble_t rx_oe_n_q;
	qbt_pkg::qbt_ctrl_t ctrl_q;
	qbt_pkg::qbt_word_t prdata_q;
	qbt_pkg::qbt_word_t rdata_d;
	logic sel_s;
	logic dclk_s;
	logic dclk_prev_q;
	logic dclk_rise;
	logic pready_q;
	logic pslverr_q;
	logic apb_setup;
	logic apb_done;
	logic addr_ctrl;
	logic addr_stat;
	logic drive_off;
	logic rx_hold;
	logic rx_tri;
	logic drv_loaded_q;
	qbt_pkg::qbt_nibble_t bus_in_prev1;
	qbt_pkg::qbt_nibble_t bus_in_prev2;

	// All local-logic and bus pin inputs cross into pclk through two flops; equal depth keeps words aligned with the clock
	qbt_sync #(
		.W(4)
	) u_sync_a (
		.pclk(pclk),
		.presetn(presetn),
		.d(word_a),
		.q(word_a_s)
	);

	qbt_sync #(
		.W(4)
	) u_sync_b (
		.pclk(pclk),
		.presetn(presetn),
		.d(word_b),
		.q(word_b_s)
	);

	qbt_sync #(
		.W(2)
	) u_sync_ctl (
		.pclk(pclk),
		.presetn(presetn),
		.d({word_select, drive_clock}),
		.q({sel_s, dclk_s})
	);

	// Own driven level is sensed on the same line
	qbt_sync #(
		.W(4)
	) u_sync_bus (
		.pclk(pclk),
		.presetn(presetn),
		.d(bus_in),
		.q(bus_s)
	);

	assign drive_off = ctrl_q[`QBT_CTRL_DRV_OFF];
	assign rx_hold = ctrl_q[`QBT_CTRL_RX_HOLD];
	assign rx_tri = ctrl_q[`QBT_CTRL_RX_TRI];

	// Edge detect on the synchronised drive clock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dclk_prev_q <= 1'b0;
		else
			dclk_prev_q <= dclk_s;
	end

	assign dclk_rise = dclk_s & ~dclk_prev_q;

	// Marks the first load, so stability checks skip the unknown power-up contents
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			drv_loaded_q <= 1'b0;
		else if (dclk_rise)
			drv_loaded_q <= 1'b1;
	end

	// Per-bit word mux in front of each driver flop; no reset by design
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_drv
			always_ff @(posedge pclk)
			begin
				if (dclk_rise)
					drv_q[gi] <= sel_s ? word_b_s[gi] : word_a_s[gi];
			end
		end
	endgenerate

	// Stored high pulls the line low, stored low or disabled releases it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_oe_n_q <= 4'hF;
		else if (drive_off)
			bus_oe_n_q <= 4'hF;
		else
			bus_oe_n_q <= ~drv_q;
	end

	// Open collector: the output level is only ever low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_out_q <= 4'h0;
		else
			bus_out_q <= 4'h0;
	end

	// Receiver latch modelled as a flop loaded each cycle while open; no reset by design
	always_ff @(posedge pclk)
	begin
		if (!rx_hold)
			rx_lat_q <= ~bus_s;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_oe_n_q <= 4'hF;
		else
			rx_oe_n_q <= {4{rx_tri}};
	end

	// APB: one wait-free access cycle after setup, pready registered
	assign apb_setup = psel & ~penable;
	assign apb_done = psel & penable & pready_q;
	assign addr_ctrl = (paddr == `QBT_CTRL_OFFS);
	assign addr_stat = (paddr == `QBT_STAT_OFFS);

	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (addr_ctrl)
			rdata_d[`QBT_CTRL_W-1:0] = ctrl_q;
		else if (addr_stat)
		begin
			rdata_d[`QBT_STAT_DRV_LSB +: 4] = drv_q;
			rdata_d[`QBT_STAT_RX_LSB +: 4] = rx_lat_q;
			rdata_d[`QBT_STAT_BUS_LSB +: 4] = bus_s;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (apb_setup)
		begin
			pready_q <= 1'b1;
			pslverr_q <= ~(addr_ctrl | addr_stat);
			prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
	end

	// Control bits default to drivers and receiver outputs off, latch open
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= `QBT_CTRL_RST;
		else if (apb_done && pwrite && addr_ctrl && pstrb[0])
			ctrl_q <= pwdata[`QBT_CTRL_W-1:0];
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign bus_out = bus_out_q;
	assign bus_oe_n = bus_oe_n_q;
	assign rx_data = rx_lat_q;
	assign rx_oe_n = rx_oe_n_q;

	default clocking cb @(posedge pclk);
	endclocking

	default disable iff (!presetn);

	// The load edge, the latch close and the control write are spelled out as named sequences
	sequence load_edge_s;
		dclk_s && !dclk_prev_q;
	endsequence

	sequence hold_close_s;
		!rx_hold ##1 rx_hold;
	endsequence

	sequence apb_write_ctrl_s;
		apb_setup && pwrite && addr_ctrl && pstrb[0] ##1 apb_done;
	endsequence

	drv_load_a: assert property (load_edge_s |=> drv_q == ($past(sel_s) ? $past(word_b_s) : $past(word_a_s)))
		else $error("driver register did not load the selected word");

	sel_first_a: assert property (load_edge_s ##0 !sel_s |=> drv_q == $past(word_a_s))
		else $error("low select did not pick the first word");

	sel_second_a: assert property (load_edge_s ##0 sel_s |=> drv_q == $past(word_b_s))
		else $error("high select did not pick the second word");

	// The power-up unknown of the driver register is not a change
	drv_steady_a: assert property (drv_loaded_q && !(dclk_s && !dclk_prev_q) |=> drv_q == $past(drv_q))
		else $error("driver register changed without a drive clock rise");

	bus_release_a: assert property (drive_off |=> bus_oe_n == 4'hF)
		else $error("bus driven while drivers are off");

	bus_only_low_a: assert property (bus_out == 4'h0 ##1 bus_out == 4'h0)
		else $error("open collector driver drove a high level");

	bus_invert_a: assert property (!drive_off |=> bus_oe_n == ~$past(drv_q))
		else $error("bus line does not carry the inverted register bit");

	load_to_bus_a: assert property (load_edge_s ##1 !drive_off |=> bus_oe_n == ~$past(drv_q))
		else $error("loaded word did not reach the bus one cycle later");

	rx_follow_a: assert property (!rx_hold |=> rx_data == ~$past(bus_s))
		else $error("open receiver latch did not follow the inverted bus");

	rx_self_a: assert property ((!rx_hold)[*2] ##0 bus_s == bus_in_prev2 |=> rx_data == ~$past(bus_s))
		else $error("receiver does not sense its own bus line");

	rx_close_a: assert property (hold_close_s |=> rx_data == $past(rx_data))
		else $error("receiver latch moved at the close");

	rx_keep_a: assert property (rx_hold[*3] |-> rx_data == $past(rx_data, 2))
		else $error("closed receiver latch did not keep its value");

	rx_open_a: assert property ((!rx_hold)[*2] |=> rx_data == ~$past(bus_s))
		else $error("transparent latch lagged the bus");

	rx_gate_a: assert property (##1 rx_oe_n == {4{$past(rx_tri)}})
		else $error("receiver outputs not gated by receive_tristate");

	ctrl_write_a: assert property (apb_write_ctrl_s |=> ctrl_q == $past(pwdata[`QBT_CTRL_W-1:0]))
		else $error("control write did not take effect");

	apb_ready_a: assert property (apb_setup |=> pready ##1 !pready)
		else $error("apb access did not complete in one cycle");

	// Register bus answers
	apb_err_a: assert property (apb_setup && !addr_ctrl && !addr_stat |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access did not answer with an error and zero data");

	apb_okay_a: assert property (apb_setup && (addr_ctrl || addr_stat) |=> !pslverr)
		else $error("mapped access answered with an error");

	pready_src_a: assert property (pready |-> $past(apb_setup))
		else $error("pready rose without a setup cycle");

	stat_read_a: assert property (apb_setup && !pwrite && addr_stat && drv_loaded_q |=>
		prdata == {20'h0_0000, $past(bus_s), $past(rx_lat_q), $past(drv_q)})
		else $error("status read did not return register, latch and bus levels");

	ctrl_keep_a: assert property (!apb_done |=> ctrl_q == $past(ctrl_q))
		else $error("control bits changed without a bus write");

	rx_on_a: assert property (!rx_tri |=> rx_oe_n == 4'h0)
		else $error("receiver outputs stayed off with receive_tristate low");

	// Helper for rx_self_a: two-cycle-old raw bus matches the synchronised view
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_in_prev1 <= 4'h0;
			bus_in_prev2 <= 4'h0;
		end
		else
		begin
			bus_in_prev1 <= bus_in;
			bus_in_prev2 <= bus_in_prev1;
		end
	end

endmodule // qbt_transceiver

// ### qbt_map.svh
`ifndef QBT_MAP_SVH
`define QBT_MAP_SVH

// APB register byte offsets
`define QBT_ADDR_W 12
`define QBT_CTRL_OFFS 12'h000
`define QBT_STAT_OFFS 12'h004

// Control register fields
`define QBT_CTRL_W 3
`define QBT_CTRL_DRV_OFF 0
`define QBT_CTRL_RX_HOLD 1
`define QBT_CTRL_RX_TRI 2
`define QBT_CTRL_RST 3'h5

// Status register fields
`define QBT_STAT_DRV_LSB 0
`define QBT_STAT_RX_LSB 4
`define QBT_STAT_BUS_LSB 8

`endif

// ### qbt_pkg.sv
`include "qbt_map.svh"

package qbt_pkg;

	typedef logic [3:0] qbt_nibble_t;

	typedef logic [`QBT_CTRL_W-1:0] qbt_ctrl_t;

	typedef logic [31:0] qbt_word_t;

endpackage

// ### qbt_sync.sv
`timescale 1ns/1ps

module qbt_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous level in, synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule // qbt_sync

// ### qbt_bus_model.sv
`timescale 1ns/1ps

module qbt_bus_model (
	// Design driver side
	input wire logic [3:0] bus_out,
	input wire logic [3:0] bus_oe_n,
	// Other wired-OR drivers, a one pulls the line low
	input wire logic [3:0] other_pull,
	// Resolved line level back to the receivers
	output logic [3:0] bus_in
);
	// Pull-up resistor: a released line reads high, never the last value
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			bus_in[i] = ((!bus_oe_n[i] && !bus_out[i]) || other_pull[i]) ? 1'b0 : 1'b1;
	end
endmodule // qbt_bus_model

// ### tb.sv
`timescale 1ns/1ps
`include "qbt_map.svh"

module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, word_a, word_b, bus_in, bus_out, bus_oe_n, rx_data, rx_oe_n, other_pull;
	logic word_select, drive_clock, er;
	int errors = 0;
	int samples_checked = 0;

	qbt_transceiver i_qbt_transceiver (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .word_a(word_a), .word_b(word_b), .word_select(word_select),
		.drive_clock(drive_clock), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
		.rx_data(rx_data), .rx_oe_n(rx_oe_n));
	qbt_bus_model i_qbt_bus_model (.bus_out(bus_out), .bus_oe_n(bus_oe_n), .other_pull(other_pull),
		.bus_in(bus_in));

	initial
	begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x)
		begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, x);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic settle();
		repeat (6) @(posedge pclk);
	endtask

	// Words are held steady well around the sampled rise
	task automatic load(input logic sel);
		word_select <= sel;
		settle();
		drive_clock <= 1;
		settle();
		drive_clock <= 0;
		settle();
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#200us;
		errors++;
		wrap_up();
	end

	initial
	begin
		presetn = 0;
		{psel, penable, pwrite, word_select, drive_clock} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		word_a = 4'hA;
		word_b = 4'h6;
		other_pull = 4'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		apb(0, `QBT_CTRL_OFFS, 32'h0);
		chk(rd, 32'h00000005);
		chk({28'h0, bus_oe_n}, 32'hF);
		chk({28'h0, rx_oe_n}, 32'hF);
		$display("reset test done");
		load(0);
		apb(0, `QBT_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000F0A);
		load(1);
		word_a <= 4'h3;
		settle();
		apb(0, `QBT_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000F06);
		chk({28'h0, bus_oe_n}, 32'hF);
		$display("driver load test done");
		apb(1, `QBT_CTRL_OFFS, 32'h0);
		settle();
		chk({28'h0, bus_oe_n}, 32'h9);
		chk({28'h0, bus_out}, 32'h0);
		chk({28'h0, rx_data}, 32'h6);
		chk({28'h0, rx_oe_n}, 32'h0);
		apb(0, `QBT_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000966);
		other_pull <= 4'h1;
		settle();
		chk({28'h0, rx_data}, 32'h7);
		$display("bus drive test done");
		apb(1, `QBT_CTRL_OFFS, 32'h2);
		other_pull <= 4'h0;
		settle();
		chk({28'h0, rx_data}, 32'h7);
		apb(0, `QBT_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000976);
		apb(1, `QBT_CTRL_OFFS, 32'h0);
		settle();
		chk({28'h0, rx_data}, 32'h6);
		apb(1, `QBT_CTRL_OFFS, 32'h4);
		settle();
		chk({28'h0, rx_oe_n}, 32'hF);
		$display("receiver latch test done");
		load(0);
		chk({28'h0, bus_oe_n}, 32'hC);
		chk({28'h0, rx_data}, 32'h3);
		apb(0, `QBT_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000C33);
		$display("driven load test done");
		apb(0, 12'h008, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("unmapped test done");
		wrap_up();
	end
endmodule // tb
